/* File: rtl/hwlc_core.sv */
// hardware loop controller of the program controller
//
// Overview of operation
// RULE1 - first cycle: load count, stack 0 to 1
// RULE2 - short immediate: six low bits, rest cleared
// RULE3 - second cycle: push body address, load end
// RULE4 - save active into nested, set third cycle
// RULE5 - end match, count not one: decrement, loop
// RULE6 - count one: restore flags, pop stack, fall through
// RULE7 - body refetched every pass, interruptible
// RULE8 - program avoids forbidden count source registers
// RULE9 - accumulator extension saturates count source
// RULE10 - saturation sets limit flag
// RULE11 - zero count runs loop 8192 times
// RULE12 - reset clears loop active flag
// RULE13 - address register write delayed one instruction
// RULE14 - end compare happens at fetch time
// RULE15 - program avoids control writes near end
// RULE16 - program avoids illegal loop start forms
// RULE17 - program avoids listed instructions near end
// RULE18 - program avoids listed instructions before last
// RULE19 - last loop word restrictions on program
// RULE20 - no stack moves just before start
// RULE21 - nested loops need distinct end addresses
// RULE22 - end address is last instruction address
// RULE23 - loop start takes two words, six cycles
// RULE24 - two entry loop stack, entry 0 top
`timescale 1ns/1ps
`default_nettype none
`include "hwlc_params.svh"
module hwlc_core
   import hwlc_pkg::*;
#(
   parameter int CNT_W = `HWLC_CNT_W,
   parameter int ADDR_W = `HWLC_ADDR_W
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic DO_START,
   input wire hwlc_src_t DO_SRC,
   input wire logic [5:0] DO_IMM,
   input wire logic [15:0] DO_REG,
   input wire logic [35:0] DO_ACC,
   input wire logic [15:0] DO_EXT,
   input wire logic [15:0] DO_PC,
   input wire logic FETCH_VALID,
   input wire logic [15:0] FETCH_PC,
   input wire logic AREG_WR,
   input wire logic [1:0] AREG_IDX,
   input wire logic [15:0] AREG_DATA,
   output logic BUSY,
   output logic REDIRECT,
   output logic [15:0] REDIRECT_PC,
   output logic LOOP_DONE,
   output logic LIMIT_SET,
   output logic [15:0] STATUS_HI,
   output logic [CNT_W-1:0] LOOP_COUNT,
   output logic [15:0] STACK_TOP,
   output logic [15:0] STACK_NEXT,
   output logic [15:0] LOOP_END,
   output logic [63:0] AREG_VIS
);
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   if (CNT_W != `HWLC_CNT_W || ADDR_W != `HWLC_ADDR_W) begin : g_width_check
      $error("hwlc_core: unsupported width");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // extension in use when bits 35..31 are not all equal
   function automatic logic acc_ext_used(input logic [35:0] a);
      acc_ext_used = !((&a[35:31]) || !(|a[35:31]));
   endfunction

   function automatic logic [12:0] count_src(input hwlc_src_t s, input logic [5:0] imm,
                                             input logic [15:0] r, input logic [35:0] a);
      logic [15:0] v;
      v = 16'h0000;
      case (s)
         HWLC_SRC_IMM: v = {10'h000, imm};
         HWLC_SRC_REG: v = r;
         HWLC_SRC_ACC: begin
            if (!acc_ext_used(a)) begin
               v = a[31:16];
            end else if (a[35]) begin
               v = `HWLC_SAT_NEG;
            end else begin
               v = `HWLC_SAT_POS;
            end
         end
         default: v = r;
      endcase
      count_src = v[12:0];
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   hwlc_state_t st_q, st_d;
   logic [2:0] tail_q, tail_d;
   logic [12:0] lc_q, lc_d;
   logic [15:0] hws0_q, hws0_d, hws1_q, hws1_d, la_q, la_d, ext_q, ext_d, pc_q, pc_d;
   logic lf_q, lf_d, nl_q, nl_d;
   logic redir_q, redir_d, done_q, done_d, lim_q, lim_d;
   logic [15:0] rpc_q, rpc_d;
   logic busy_q, busy_d;
   logic [63:0] areg_q, areg_d;
   logic match;

   always_comb begin
      st_d = st_q;
      tail_d = tail_q;
      lc_d = lc_q;
      hws0_d = hws0_q;
      hws1_d = hws1_q;
      la_d = la_q;
      ext_d = ext_q;
      pc_d = pc_q;
      lf_d = lf_q;
      nl_d = nl_q;
      redir_d = 1'b0;
      done_d = 1'b0;
      lim_d = 1'b0;
      rpc_d = rpc_q;
      areg_d = areg_q;
      // end compare at fetch time, only once the loop is armed
      match = lf_q && FETCH_VALID && (FETCH_PC == la_q);
      // RULE13 new value visible after one instruction
      if (AREG_WR) begin
         areg_d[AREG_IDX*16 +: 16] = AREG_DATA;
      end
      case (st_q)
         HWLC_IDLE: begin
            if (DO_START) begin
               // RULE1 load count, copy stack
               // RULE2 immediate zero-extended
               lc_d = count_src(DO_SRC, DO_IMM, DO_REG, DO_ACC);
               hws1_d = hws0_q;
               ext_d = DO_EXT;
               pc_d = DO_PC;
               // RULE9 RULE10 saturation flags limit
               lim_d = (DO_SRC == HWLC_SRC_ACC) && acc_ext_used(DO_ACC);
               st_d = HWLC_C2;
            end
         end
         HWLC_C2: begin
            // RULE3 push body address, load end
            hws0_d = pc_q;
            la_d = ext_q;
            // RULE4 save previous active flag
            nl_d = lf_q;
            st_d = HWLC_C3;
         end
         HWLC_C3: begin
            // RULE4 set active flag
            lf_d = 1'b1;
            tail_d = 3'(`HWLC_DO_CYCLES - 4);
            st_d = HWLC_TAIL;
         end
         HWLC_TAIL: begin
            // RULE23 pad out to six cycles
            if (tail_q == 3'h0) begin
               st_d = HWLC_IDLE;
            end else begin
               tail_d = tail_q - 3'h1;
            end
         end
         default: st_d = HWLC_IDLE;
      endcase
      // RULE14 compare at fetch
      if (match && st_q == HWLC_IDLE && !DO_START) begin
         if (lc_q != 13'h0001) begin
            // RULE5 decrement and return to top
            // RULE11 zero wraps to full range
            // RULE7 body is refetched
            lc_d = lc_q - 13'h0001;
            redir_d = 1'b1;
            rpc_d = hws0_q;
         end else begin
            // RULE6 end-of-loop processing
            // RULE24 two entry stack pop
            lf_d = nl_q;
            nl_d = 1'b0;
            hws0_d = hws1_q;
            done_d = 1'b1;
         end
      end
      // busy registered so the output comes from a flop
      busy_d = (st_d != HWLC_IDLE);
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         st_q <= HWLC_IDLE;
         tail_q <= 3'h0;
         lc_q <= 13'h0000;
         hws0_q <= 16'h0000;
         hws1_q <= 16'h0000;
         la_q <= 16'h0000;
         ext_q <= 16'h0000;
         pc_q <= 16'h0000;
         // RULE12 reset clears active flag
         lf_q <= 1'b0;
         nl_q <= 1'b0;
         redir_q <= 1'b0;
         done_q <= 1'b0;
         lim_q <= 1'b0;
         rpc_q <= 16'h0000;
         busy_q <= 1'b0;
         areg_q <= 64'h0;
      end else begin
         st_q <= st_d;
         tail_q <= tail_d;
         lc_q <= lc_d;
         hws0_q <= hws0_d;
         hws1_q <= hws1_d;
         la_q <= la_d;
         ext_q <= ext_d;
         pc_q <= pc_d;
         lf_q <= lf_d;
         nl_q <= nl_d;
         redir_q <= redir_d;
         done_q <= done_d;
         lim_q <= lim_d;
         rpc_q <= rpc_d;
         busy_q <= busy_d;
         areg_q <= areg_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign BUSY = busy_q;
   assign REDIRECT = redir_q;
   assign REDIRECT_PC = rpc_q;
   assign LOOP_DONE = done_q;
   assign LIMIT_SET = lim_q;
   assign STATUS_HI = {lf_q, 15'h0000};
   assign LOOP_COUNT = lc_q;
   assign STACK_TOP = hws0_q;
   assign STACK_NEXT = hws1_q;
   assign LOOP_END = la_q;
   assign AREG_VIS = areg_q;
endmodule
`default_nettype wire

/* File: rtl/hwlc_params.svh */
// constants for the hardware loop controller
`ifndef HWLC_PARAMS_SVH
`define HWLC_PARAMS_SVH
`define HWLC_CNT_W 13
`define HWLC_ADDR_W 16
`define HWLC_IMM_W 6
`define HWLC_ACC_W 36
`define HWLC_SR_LF_BIT 15
`define HWLC_SR_L_BIT 6
`define HWLC_DO_CYCLES 6
`define HWLC_SAT_POS 16'h7FFF
`define HWLC_SAT_NEG 16'h8000
`endif

/* File: rtl/hwlc_pkg.sv */
// types for the hardware loop controller
`include "hwlc_params.svh"
package hwlc_pkg;
   typedef enum logic [3:0] {
      HWLC_IDLE = 4'h1,
      HWLC_C2 = 4'h2,
      HWLC_C3 = 4'h4,
      HWLC_TAIL = 4'h8
   } hwlc_state_t;
   typedef enum logic [1:0] {
      HWLC_SRC_IMM = 2'h0,
      HWLC_SRC_REG = 2'h1,
      HWLC_SRC_ACC = 2'h2
   } hwlc_src_t;
endpackage

/* File: tb/hwlc_checker.sv */
// property checker for the hardware loop controller
`timescale 1ns/1ps
`default_nettype none
module hwlc_checker
   import hwlc_pkg::*;
#(parameter int CNT_W = 13) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic DO_START,
   input wire logic FETCH_VALID,
   input wire logic BUSY,
   input wire logic REDIRECT,
   input wire logic LOOP_DONE,
   input wire logic LIMIT_SET,
   input wire hwlc_src_t DO_SRC,
   input wire logic [5:0] DO_IMM,
   input wire logic [35:0] DO_ACC,
   input wire logic [15:0] DO_PC,
   input wire logic [15:0] DO_EXT,
   input wire logic [15:0] FETCH_PC,
   input wire logic [15:0] REDIRECT_PC,
   input wire logic [15:0] STATUS_HI,
   input wire logic [15:0] STACK_TOP,
   input wire logic [15:0] STACK_NEXT,
   input wire logic [15:0] LOOP_END,
   input wire logic [CNT_W-1:0] LOOP_COUNT
);
   logic t;
   logic m;
   logic sat;
   assign t = DO_START && !BUSY;
   assign m = FETCH_VALID && STATUS_HI[15] && !BUSY && !DO_START && FETCH_PC == LOOP_END;
   assign sat = !(&DO_ACC[35:31]) && (|DO_ACC[35:31]);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   a_count_imm: assert property (
      t && DO_SRC == HWLC_SRC_IMM |=> LOOP_COUNT == {7'h0, $past(DO_IMM)}) else $error("bad count");
   a_stack_copy: assert property (
      t |=> STACK_NEXT == $past(STACK_TOP)) else $error("bad stack copy");
   a_push_end: assert property (
      t |=> ##1 STACK_TOP == $past(DO_PC, 2) && LOOP_END == $past(DO_EXT, 2)) else $error("bad push");
   a_flag_set: assert property (
      t |-> ##3 STATUS_HI[15]) else $error("flag not set");
   a_busy_len: assert property (
      t |=> BUSY[*5] ##1 !BUSY) else $error("bad busy length");
   a_loop_back: assert property (
      m && LOOP_COUNT != 13'h1 |=> REDIRECT && REDIRECT_PC == STACK_TOP
      && LOOP_COUNT == $past(LOOP_COUNT) - 13'h1) else $error("bad loop back");
   a_loop_exit: assert property (
      m && LOOP_COUNT == 13'h1 |=> LOOP_DONE && !REDIRECT && STACK_TOP == $past(STACK_NEXT))
      else $error("bad loop exit");
   a_sat_limit: assert property (
      t && DO_SRC == HWLC_SRC_ACC && sat |=> LIMIT_SET && LOOP_COUNT == {13{!$past(DO_ACC[35])}})
      else $error("bad saturation");
   a_reset_clr: assert property (
      disable iff (1'b0) !RESETN |=> STATUS_HI == 16'h0) else $error("flag kept in reset");
   c_exit: cover property (m && LOOP_COUNT == 13'h1);
   c_sat: cover property (t && sat);
   c_zero: cover property (m && LOOP_COUNT == 13'h0);
endmodule
bind hwlc_core hwlc_checker #(.CNT_W(CNT_W)) i_chk (.*);
`default_nettype wire

/* File: tb/hwlc_fetch_model.sv */
// fetch stage model walking a straight loop body
`timescale 1ns/1ps
`default_nettype none
module hwlc_fetch_model (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic REDIRECT,
   input wire logic fetch_en,
   input wire logic fetch_slow,
   input wire logic [15:0] REDIRECT_PC,
   input wire logic [15:0] fetch_base,
   output logic FETCH_VALID,
   output logic [15:0] FETCH_PC
);
   logic started_q;
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         {started_q, FETCH_VALID, FETCH_PC} <= 18'h0;
      end else if (!fetch_en) begin
         {started_q, FETCH_VALID, FETCH_PC} <= {2'h0, ~FETCH_PC};
      end else if (!started_q) begin
         {started_q, FETCH_VALID, FETCH_PC} <= {2'h3, fetch_base};
      end else if (REDIRECT) begin
         {FETCH_VALID, FETCH_PC} <= {1'b1, REDIRECT_PC};
      end else begin
         FETCH_VALID <= !(fetch_slow && FETCH_VALID);
         FETCH_PC <= FETCH_VALID ? FETCH_PC + 16'h1 : FETCH_PC;
      end
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the hardware loop controller
`timescale 1ns/1ps
`default_nettype none
module testbench
   import hwlc_pkg::*;
;
   logic MCLK = 1'b0, RESETN = 1'b0, DO_START = 1'b0, AREG_WR = 1'b0;
   logic fetch_en = 1'b0, fetch_slow = 1'b0;
   hwlc_src_t DO_SRC = HWLC_SRC_IMM;
   logic [5:0] DO_IMM = 6'h0;
   logic [1:0] AREG_IDX = 2'h0;
   logic [35:0] DO_ACC = 36'h0;
   logic [15:0] DO_REG = 16'h0, DO_EXT = 16'h0, DO_PC = 16'h0, AREG_DATA = 16'h0;
   logic [15:0] fetch_base = 16'h0;
   logic FETCH_VALID, BUSY, REDIRECT, LOOP_DONE, LIMIT_SET;
   logic [15:0] FETCH_PC, REDIRECT_PC, STATUS_HI, STACK_TOP, STACK_NEXT, LOOP_END;
   logic [12:0] LOOP_COUNT;
   logic [63:0] AREG_VIS;
   int failures = 0;
   int tests_run = 0;
   hwlc_core i_dut (.*);
   hwlc_fetch_model i_fetch (.*);
   always #20 MCLK = ~MCLK;
   task automatic wrap_up();
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(logic [15:0] got, logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [12:0] exp_cnt(hwlc_src_t s, logic [15:0] r, logic [35:0] a);
      if (s == HWLC_SRC_IMM) return {7'h0, r[5:0]};
      if (s == HWLC_SRC_REG) return r[12:0];
      if ((&a[35:31]) || !(|a[35:31])) return a[28:16];
      return a[35] ? 13'h0 : 13'h1FFF;
   endfunction
   task automatic start(hwlc_src_t s, logic [15:0] r, logic [35:0] a, logic [15:0] p);
      DO_SRC = s;
      DO_REG = r;
      DO_IMM = r[5:0];
      DO_ACC = a;
      DO_PC = p;
      DO_EXT = p + 16'h2;
      DO_START = 1'b1;
      @(negedge MCLK);
      DO_START = 1'b0;
      check(LOOP_COUNT, exp_cnt(s, r, a));
      check(LIMIT_SET, 16'(s == HWLC_SRC_ACC && a[35:31] != {5{a[31]}}));
      repeat (5) @(negedge MCLK);
      check(BUSY, 16'h0);
      check(STACK_TOP, p);
      check(LOOP_END, p + 16'h2);
      check(STATUS_HI, 16'h8000);
   endtask
   task automatic run(logic [15:0] b, int n);
      int k;
      int rd;
      rd = 0;
      fetch_base = b;
      fetch_en = 1'b1;
      for (k = 0; k < 60000; k++) begin
         @(negedge MCLK);
         fetch_slow = ($urandom % 4) == 0;
         if (REDIRECT === 1'b1) begin
            rd++;
            check(REDIRECT_PC, b);
         end
         if (LOOP_DONE === 1'b1) break;
      end
      fetch_en = 1'b0;
      check(16'(rd), 16'(n - 1));
      if (k == 60000) begin
         failures++;
         wrap_up();
      end
   endtask
   initial begin
      int i;
      logic [15:0] r;
      logic [35:0] a;
      void'($urandom(55));
      repeat (4) @(negedge MCLK);
      RESETN = 1'b1;
      check(STATUS_HI, 16'h0);
      r = 16'($urandom_range(63, 1));
      start(HWLC_SRC_IMM, r, 36'h0, 16'h0100);
      run(16'h0100, int'(r));
      check(STATUS_HI, 16'h0);
      check(STACK_TOP, 16'h0);
      start(HWLC_SRC_IMM, 16'h5, 36'h0, 16'h0100);
      start(HWLC_SRC_IMM, 16'h1, 36'h0, 16'h0200);
      check(STACK_NEXT, 16'h0100);
      run(16'h0200, 1);
      check(STATUS_HI, 16'h8000);
      check(STACK_TOP, 16'h0100);
      RESETN = 1'b0;
      @(negedge MCLK);
      check(STATUS_HI, 16'h0);
      RESETN = 1'b1;
      for (i = 0; i < 9; i++) begin
         r = 16'($urandom);
         a = {4'($urandom), 32'($urandom)};
         if (i == 2) a = 36'h0_8000_0000;
         if (i == 5) a = 36'hF_FFFF_0000;
         {AREG_WR, AREG_IDX, AREG_DATA} = {1'b1, 2'(i), r};
         @(negedge MCLK);
         AREG_WR = 1'b0;
         check(AREG_VIS[i % 4 * 16 +: 16], r);
         start(hwlc_src_t'(i % 3), r, a, 16'($urandom));
      end
      start(HWLC_SRC_ACC, 16'h0, 36'h8_0000_0000, 16'h0300);
      run(16'h0300, 8192);
      wrap_up();
   end
endmodule
`default_nettype wire
